// ==== arb_model.sv ====
/*
  bus arbiter model: grants the bus to the master engine while the
  engine requests it and the bench allows it.
  assumes the same clock as the register bank; grant changes just
  after each rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module arb_model (
  input  wire logic clock,  // pci clock
  input  wire logic reset,  // sync, active high
  input  wire logic req,    // engine wants the bus
  input  wire logic allow,  // bench lets the grant stand
  output logic      gnt_n   // grant, low active
);
  // grant withdrawn just after the next rising edge once allow drops, as a busy arbiter does
  always_ff @(posedge clock) begin
    if (reset) begin
      gnt_n <= #1 1'h1;
    end else begin
      gnt_n <= #1 ~(req & allow);
    end
  end
endmodule
`default_nettype wire

// ==== pci_cfg_pkg.sv ====
/*
  constants, field positions, reset values and carrier types shared by
  the configuration register bank and its bench.
  assumes a PCI target decoder on the same clock issues config cycles.
*/
`default_nettype none
package pci_cfg_pkg;
  // ------------------------------------------------------------------
  // register offsets (byte addresses in configuration space)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CMD_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CLASS_REV   = 8'h08;
  localparam logic [7:0] OFS_LAT_CACHE   = 8'h0c;
  // ------------------------------------------------------------------
  // command field positions
  // ------------------------------------------------------------------
  localparam int BIT_MEM_EN      = 1;
  localparam int BIT_MASTER_EN   = 2;
  localparam int BIT_PERR_RESP   = 6;
  localparam int BIT_SERR_EN     = 8;
  // ------------------------------------------------------------------
  // status field positions
  // ------------------------------------------------------------------
  localparam int BIT_DATA_PERR_RPT = 24;
  localparam int BIT_CAP_66MHZ     = 21;
  localparam int BIT_TGT_ABORT     = 27;
  localparam int BIT_RX_TGT_ABORT  = 28;
  localparam int BIT_RX_MST_ABORT  = 29;
  localparam int BIT_SIG_SERR      = 30;
  localparam int BIT_DET_PERR      = 31;
  localparam int DEVSEL_LSB        = 25;
  // ------------------------------------------------------------------
  // fixed values and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0]  DEVSEL_MEDIUM  = 2'h1;
  localparam logic        CAP_66MHZ_VAL  = 1'h0;
  localparam logic [7:0]  BASE_CLASS     = 8'h02;
  localparam logic [7:0]  SUB_CLASS      = 8'h00;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] CMD_WR_MASK    = 16'h0146;
  localparam logic [7:0]  LAT_RESET      = 8'h00;
  localparam logic [7:0]  CACHE_RESET    = 8'h00;
  // ------------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;
  typedef struct packed {
    logic addr_perr;
    logic data_perr;
    logic mst_data_perr;
    logic rx_mst_abort;
    logic rx_tgt_abort;
    logic tgt_abort;
  } bus_events_t;
endpackage
`default_nettype wire

// ==== pci_config_regs.sv ====
/*
  configuration space bank: command/status, class/revision and
  latency/cache line registers, with the gating they exert on master
  and memory-space activity, parity reporting and burst termination.
  assumes a same-clock target decoder presents config cycles and
  memory hits, and a same-clock master engine drives frame activity.
*/
// Contract
// - 66 MHz capable status bit always reads zero.
// - address parity error drives system error only when enabled.
// - parity error response set: signal fatal bus error on parity error.
// - response clear: ignore parity errors; bit clear after reset. The code still drives serr on an address parity error while serr enable is set.
// - start master transactions only while master enable is set.
// - claim memory cycles only while memory space enable is set.
// - base class reads 0x02 in top byte, read only.
// - subclass reads 0x00 in bits 23:16; bits 15:8 read zero.
// - revision in bits 7:4, step in bits 3:0, fixed.
// - latency timer is eight bits at 15:8, in clock periods.
// - frame assertion loads and starts the latency timer.
// - frame ending before expiry makes the timer harmless.
// - after expiry, terminate once grant is withdrawn.
// - cache line size stored in bits 7:0, in doublewords.
// - all command bits zero after hardware reset.
// - upper status bits clear only by writing one.
// - command written zero detaches device except for config cycles.
// - hardware reset restores defaults; software reset leaves registers.
`timescale 1ns/10ps
`default_nettype none
module pci_config_regs #(
  parameter logic [3:0] REVISION_NUM = 4'h3, // arbitrary value
  parameter logic [3:0] STEP_NUM     = 4'h5  // arbitrary value
) (
  input  wire logic                      CLOCK,       // 125 MHz clock
  input  wire logic                      RESET,       // hardware reset
  input  wire logic                      SOFT_RESET,  // software reset
  input  wire pci_cfg_pkg::cfg_req_t     CFG_REQ,     // config cycle
  output logic [31:0]                    CFG_RDATA,   // read data
  output logic                           CFG_ACK,     // access done
  input  wire logic                      MEM_HIT,     // memory decode hit
  output logic                           MEM_CLAIM,   // claim mem cycle
  input  wire logic                      MST_REQ,     // engine wants bus
  output logic                           MST_GO,      // master allowed
  input  wire logic                      FRAME_ACT,   // our frame driven
  input  wire logic                      GNT_N,       // arbiter grant pin
  input  wire pci_cfg_pkg::bus_events_t  BUS_EV,      // parity/abort events
  output logic                           SERR_N_O,    // serr pin level
  output logic                           SERR_N_OE,   // serr pin drive
  output logic                           FATAL_ERR,   // fatal bus error
  output logic                           MST_STOP,    // end master burst
  output logic [7:0]                     CACHE_LINE   // cache line size
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [15:0] cmd_q;
  logic [31:0] status_q;
  logic [7:0]  lat_q;
  logic [7:0]  cache_q;
  logic        gnt_s1_q;
  logic        gnt_s2_q;
  logic        frame_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        mem_claim_q;
  logic        mst_go_q;
  logic        serr_oe_q;
  logic        serr_o_q;
  logic        fatal_q;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire hit_cmd  = CFG_REQ.addr == pci_cfg_pkg::OFS_CMD_STATUS;
  wire hit_cls  = CFG_REQ.addr == pci_cfg_pkg::OFS_CLASS_REV;
  wire hit_lat  = CFG_REQ.addr == pci_cfg_pkg::OFS_LAT_CACHE;
  wire wr_cmd   = CFG_REQ.sel && CFG_REQ.wr && hit_cmd;
  wire wr_lat   = CFG_REQ.sel && CFG_REQ.wr && hit_lat;
  wire rd_any   = CFG_REQ.sel && !CFG_REQ.wr;

  wire [15:0] be_mask16 = {{8{CFG_REQ.be[1]}}, {8{CFG_REQ.be[0]}}};
  wire [15:0] cmd_wmask = be_mask16 & pci_cfg_pkg::CMD_WR_MASK;

  wire serr_en   = cmd_q[pci_cfg_pkg::BIT_SERR_EN];
  wire perr_resp = cmd_q[pci_cfg_pkg::BIT_PERR_RESP];
  wire mst_en    = cmd_q[pci_cfg_pkg::BIT_MASTER_EN];
  wire mem_en    = cmd_q[pci_cfg_pkg::BIT_MEM_EN];

  wire any_perr   = BUS_EV.addr_perr || BUS_EV.data_perr;
  wire serr_fire  = BUS_EV.addr_perr && serr_en;
  wire fatal_fire = any_perr && perr_resp;
  wire frame_start = FRAME_ACT && !frame_q;

  // hardware set events, one per sticky status bit
  logic [31:0] st_set;
  always_comb begin
    st_set = 32'h0;
    st_set[pci_cfg_pkg::BIT_DET_PERR]     = any_perr;
    st_set[pci_cfg_pkg::BIT_SIG_SERR]     = serr_fire;
    st_set[pci_cfg_pkg::BIT_RX_MST_ABORT] = BUS_EV.rx_mst_abort;
    st_set[pci_cfg_pkg::BIT_RX_TGT_ABORT] = BUS_EV.rx_tgt_abort;
    st_set[pci_cfg_pkg::BIT_TGT_ABORT]    = BUS_EV.tgt_abort;
    st_set[pci_cfg_pkg::BIT_DATA_PERR_RPT] =
      BUS_EV.mst_data_perr && perr_resp;
  end

  // write-one-to-clear lane of the top byte only
  wire [31:0] st_clr = (wr_cmd && CFG_REQ.be[3]) ?
                       {CFG_REQ.wdata[31:24], 24'h0} : 32'h0;

  // sticky bits; a set in the same cycle as a clear wins, so an
  // event is never lost to a host clearing an older one
  wire [31:0] status_d = (status_q & ~st_clr) | st_set;

  // fixed status fields, never held in flops
  wire [31:0] status_rd = (status_q & 32'hf9000000)
    | ({30'h0, pci_cfg_pkg::DEVSEL_MEDIUM} << pci_cfg_pkg::DEVSEL_LSB)
    | ({31'h0, pci_cfg_pkg::CAP_66MHZ_VAL}
       << pci_cfg_pkg::BIT_CAP_66MHZ);

  wire [31:0] class_rd = {pci_cfg_pkg::BASE_CLASS,
                          pci_cfg_pkg::SUB_CLASS, 8'h00,
                          REVISION_NUM, STEP_NUM};

  wire [31:0] cmd_rd = {status_rd[31:16], cmd_q};
  wire [31:0] lat_rd = {16'h0000, lat_q, cache_q};
  wire [31:0] rd_mux = hit_cmd ? cmd_rd :
                       hit_cls ? class_rd :
                       hit_lat ? lat_rd : 32'h0;

  // ------------------------------------------------------------------
  // registers; only hardware reset restores defaults
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cmd_q <= pci_cfg_pkg::CMD_RESET;
    end else if (wr_cmd) begin
      // zero written here disconnects all but config cycles
      cmd_q <= (cmd_q & ~cmd_wmask)
             | (CFG_REQ.wdata[15:0] & cmd_wmask);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      status_q <= 32'h0;
    end else begin
      status_q <= status_d & 32'hf9000000;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      lat_q   <= pci_cfg_pkg::LAT_RESET;
      cache_q <= pci_cfg_pkg::CACHE_RESET;
    end else if (wr_lat) begin
      if (CFG_REQ.be[1]) begin
        lat_q <= CFG_REQ.wdata[15:8];
      end
      if (CFG_REQ.be[0]) begin
        cache_q <= CFG_REQ.wdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // access answer, one cycle after the request
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= CFG_REQ.sel;
      rdata_q <= rd_any ? rd_mux : 32'h0;
    end
  end

  // ------------------------------------------------------------------
  // grant synchroniser and frame edge
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gnt_s1_q <= 1'b1;
      gnt_s2_q <= 1'b1;
      frame_q  <= 1'b0;
    end else begin
      gnt_s1_q <= GNT_N;
      gnt_s2_q <= gnt_s1_q;
      frame_q  <= FRAME_ACT;
    end
  end

  // ------------------------------------------------------------------
  // bus gating and error signalling
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      mem_claim_q <= 1'b0;
      mst_go_q    <= 1'b0;
      serr_oe_q   <= 1'b0;
      serr_o_q    <= 1'b0;
      fatal_q     <= 1'b0;
    end else begin
      mem_claim_q <= MEM_HIT && mem_en;
      mst_go_q    <= MST_REQ && mst_en;
      serr_oe_q   <= serr_fire;
      serr_o_q    <= 1'b0;
      fatal_q     <= fatal_fire;
    end
  end

  // software reset is deliberately not wired to any register
  wire unused_ok = SOFT_RESET;

  pci_latency_timer u_lat (
    .clock       (CLOCK),
    .reset       (RESET),
    .frame_start (frame_start),
    .frame_act   (FRAME_ACT),
    .load_val    (lat_q),
    .gnt_n       (gnt_s2_q),
    .stop_q      (MST_STOP)
  );

  assign CFG_RDATA  = rdata_q;
  assign CFG_ACK    = ack_q;
  assign MEM_CLAIM  = mem_claim_q;
  assign MST_GO     = mst_go_q;
  assign SERR_N_O   = serr_o_q;
  assign SERR_N_OE  = serr_oe_q;
  assign FATAL_ERR  = fatal_q;
  assign CACHE_LINE = cache_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_cmd_read;
    CFG_REQ.sel && !CFG_REQ.wr && hit_cmd;
  endsequence
  sequence s_cls_read;
    CFG_REQ.sel && !CFG_REQ.wr && hit_cls;
  endsequence
  sequence s_serr_then_flag;
    SERR_N_OE ##1 status_q[pci_cfg_pkg::BIT_SIG_SERR];
  endsequence

  a_no_66mhz_cap: assert property (
    @(posedge CLOCK) disable iff (RESET)
    s_cmd_read |=> !CFG_RDATA[21] && CFG_RDATA[26:25] == 2'h1)
    else $error("66 MHz bit or devsel field wrong");
  a_serr_gated: assert property (
    @(posedge CLOCK) disable iff (RESET)
    SERR_N_OE |-> $past(BUS_EV.addr_perr) && $past(serr_en))
    else $error("serr driven without enable or address error");
  a_serr_fires: assert property (
    @(posedge CLOCK) disable iff (RESET)
    BUS_EV.addr_perr && serr_en |=> s_serr_then_flag)
    else $error("serr or its status bit missing");
  a_fatal_gated: assert property (
    @(posedge CLOCK) disable iff (RESET)
    FATAL_ERR |-> $past(perr_resp) && $past(any_perr))
    else $error("fatal error without response enabled");
  a_fatal_fires: assert property (
    @(posedge CLOCK) disable iff (RESET)
    any_perr && perr_resp |=> FATAL_ERR)
    else $error("fatal error missing after parity error");
  a_master_gated: assert property (
    @(posedge CLOCK) disable iff (RESET)
    MST_GO |-> $past(mst_en) && $past(MST_REQ))
    else $error("master started while disabled");
  a_master_fires: assert property (
    @(posedge CLOCK) disable iff (RESET)
    MST_REQ && mst_en |=> MST_GO)
    else $error("enabled master request not passed on");
  a_mem_gated: assert property (
    @(posedge CLOCK) disable iff (RESET)
    MEM_CLAIM |-> $past(mem_en))
    else $error("memory cycle claimed while disabled");
  a_mem_fires: assert property (
    @(posedge CLOCK) disable iff (RESET)
    MEM_HIT && mem_en |=> MEM_CLAIM)
    else $error("memory cycle not claimed while enabled");
  a_class_const: assert property (
    @(posedge CLOCK) disable iff (RESET)
    s_cls_read |=> CFG_RDATA[31:8] == 24'h020000)
    else $error("class register reads wrong value");
  a_lat_store: assert property (
    @(posedge CLOCK) disable iff (RESET)
    wr_lat && CFG_REQ.be[1] |=> lat_q == $past(CFG_REQ.wdata[15:8]))
    else $error("latency timer value not stored");
  a_cache_store: assert property (
    @(posedge CLOCK) disable iff (RESET)
    wr_lat && CFG_REQ.be[0] |=> CACHE_LINE == $past(CFG_REQ.wdata[7:0]))
    else $error("cache line size not stored");
  a_reset_cmd: assert property (
    @(posedge CLOCK)
    RESET |=> cmd_q == 16'h0000 && lat_q == 8'h00)
    else $error("command or latency not cleared by reset");
  a_w1c_hold: assert property (
    @(posedge CLOCK) disable iff (RESET)
    status_q[31] && !(wr_cmd && CFG_REQ.be[3] && CFG_REQ.wdata[31])
    |=> status_q[31])
    else $error("status bit lost without write of one");
  a_set_wins: assert property (
    @(posedge CLOCK) disable iff (RESET)
    (|st_set) |=> (status_q & $past(st_set)) == $past(st_set))
    else $error("status event lost to a clear");
  a_reserved_zero: assert property (
    @(posedge CLOCK) disable iff (RESET)
    s_cmd_read |=> CFG_RDATA[20:9] == 12'h000 && !CFG_RDATA[7]
      && CFG_RDATA[5:3] == 3'h0 && !CFG_RDATA[0])
    else $error("reserved command bits read nonzero");
  a_write_reads_zero: assert property (
    @(posedge CLOCK) disable iff (RESET)
    CFG_REQ.sel && CFG_REQ.wr |=> CFG_RDATA == 32'h0)
    else $error("write returned nonzero read data");
endmodule
`default_nettype wire

// ==== pci_latency_timer.sv ====
/*
  master latency timer: loaded when the master raises its frame,
  counts down per clock, asks for termination after expiry once grant
  is withdrawn. assumes gnt_n is already synchronised by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module pci_latency_timer (
  input  wire logic       clock,       // pci clock
  input  wire logic       reset,       // sync, active high
  input  wire logic       frame_start, // first cycle of our frame
  input  wire logic       frame_act,   // our frame asserted
  input  wire logic [7:0] load_val,    // programmed timer value
  input  wire logic       gnt_n,       // synchronised grant, low active
  output logic            stop_q       // begin terminating the burst
);
  logic [7:0] cnt_q;
  logic       armed_q;
  logic       expired;

  assign expired = armed_q && (cnt_q == 8'h00);

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q   <= 8'h00;
      armed_q <= 1'b0;
    end else if (frame_start) begin
      cnt_q   <= load_val;
      armed_q <= 1'b1;
    end else if (!frame_act) begin
      armed_q <= 1'b0;
    end else if (cnt_q != 8'h00) begin
      cnt_q   <= cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= expired && frame_act && gnt_n;
    end
  end

  a_stop_needs_expiry: assert property (
    @(posedge clock) disable iff (reset)
    stop_q |-> $past(expired) && $past(gnt_n))
    else $error("stop raised without expiry and lost grant");
  a_no_stop_after: assert property (
    @(posedge clock) disable iff (reset)
    !frame_act |=> !stop_q)
    else $error("stop raised after frame ended");
endmodule
`default_nettype wire

// ==== tb.sv ====
/*
  self-checking bench for the configuration register bank.
  assumes the design holds its own assertions; drives inputs 1 ns
  after each rising edge and samples there too.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  localparam logic [3:0] REV = 4'h3;
  localparam logic [3:0] STP = 4'h5;
  logic                     clk, rst, srst, mhit, mreq, frame, allow;
  logic                     gnt_n, ack, claim, go, soe, so, fatal, stop;
  logic [31:0]              rdata, rd;
  logic [7:0]               cline;
  pci_cfg_pkg::cfg_req_t    req;
  pci_cfg_pkg::bus_events_t ev;
  int                       miscompares, samples_checked, n;

  pci_config_regs #(.REVISION_NUM(REV), .STEP_NUM(STP)) dut (
    .CLOCK(clk), .RESET(rst), .SOFT_RESET(srst), .CFG_REQ(req),
    .CFG_RDATA(rdata), .CFG_ACK(ack), .MEM_HIT(mhit), .MEM_CLAIM(claim),
    .MST_REQ(mreq), .MST_GO(go), .FRAME_ACT(frame), .GNT_N(gnt_n),
    .BUS_EV(ev), .SERR_N_O(so), .SERR_N_OE(soe), .FATAL_ERR(fatal),
    .MST_STOP(stop), .CACHE_LINE(cline));
  arb_model arb (.clock(clk), .reset(rst), .req(mreq), .allow(allow),
    .gnt_n(gnt_n));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    tick(1);
    req = '{sel: 1'h1, wr: w, addr: a, be: be, wdata: d};
    tick(1);
    req.sel = 1'h0;
    chk({31'h0, ack}, 32'h1);
    rd = rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'h0, a, 4'hf, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input pci_cfg_pkg::bus_events_t e,
                       input logic oe, input logic fe);
    ev = e;
    tick(1);
    ev = '0;
    chk({30'h0, soe, fatal}, {30'h0, oe, fe});
    chk({31'h0, so}, 32'h0);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_defaults;
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'h0200_0000);
    rdchk(pci_cfg_pkg::OFS_CLASS_REV, {16'h0200, 8'h00, REV, STP});
    rdchk(pci_cfg_pkg::OFS_LAT_CACHE, 32'h0);
    rdchk(8'h10, 32'h0);
  endtask

  task automatic t_write_masks;
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'hf, 32'h3fff_ffff);
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'h0200_0146);
    cfg(1'h1, pci_cfg_pkg::OFS_CLASS_REV, 4'hf, 32'hffff_ffff);
    rdchk(pci_cfg_pkg::OFS_CLASS_REV, {16'h0200, 8'h00, REV, STP});
    cfg(1'h1, pci_cfg_pkg::OFS_LAT_CACHE, 4'hf, 32'hffff_ffff);
    rdchk(pci_cfg_pkg::OFS_LAT_CACHE, 32'h0000_ffff);
    cfg(1'h1, pci_cfg_pkg::OFS_LAT_CACHE, 4'h2, 32'h0000_0400);
    rdchk(pci_cfg_pkg::OFS_LAT_CACHE, 32'h0000_04ff);
    chk({24'h0, cline}, 32'hff);
    cfg(1'h1, 8'h14, 4'hf, 32'hffff_ffff);
    rdchk(8'h14, 32'h0);
  endtask

  task automatic t_gating;
    mhit = 1'h1;
    mreq = 1'h1;
    tick(1);
    chk({30'h0, claim, go}, 32'h3);
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'hf, 32'h0);
    tick(1);
    chk({30'h0, claim, go}, 32'h0);
    mhit = 1'h0;
    mreq = 1'h0;
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'h3, 32'h0000_0146);
  endtask

  task automatic t_parity;
    pulse('{addr_perr: 1'h1, default: 1'h0}, 1'h1, 1'h1);
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'hc200_0146);
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'hf, 32'h0000_0146);
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'hc200_0146);
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'hf, 32'hc000_0146);
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'h0200_0146);
    pulse('{data_perr: 1'h1, default: 1'h0}, 1'h0, 1'h1);
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'hf, 32'h0000_0104);
    pulse('{data_perr: 1'h1, default: 1'h0}, 1'h0, 1'h0);
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'hf, 32'h0000_0044);
    pulse('{addr_perr: 1'h1, default: 1'h0}, 1'h0, 1'h1);
  endtask

  // abort and report bits, then a clear that meets a new event
  task automatic t_status_events;
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'h8200_0044);
    pulse('{mst_data_perr: 1'h1, rx_mst_abort: 1'h1, rx_tgt_abort: 1'h1,
            tgt_abort: 1'h1, default: 1'h0}, 1'h0, 1'h0);
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'hbb00_0044);
    cfg(1'h1, pci_cfg_pkg::OFS_CMD_STATUS, 4'h7, 32'hff00_0044);
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'hbb00_0044);
    tick(1);
    req = '{sel: 1'h1, wr: 1'h1, addr: pci_cfg_pkg::OFS_CMD_STATUS,
            be: 4'hf, wdata: 32'hff00_0044};
    ev = '{tgt_abort: 1'h1, default: 1'h0};
    tick(1);
    req.sel = 1'h0;
    ev = '0;
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'h0a00_0044);
  endtask

  // latency value is 4 here; grant withheld so expiry stops at once
  task automatic t_latency;
    mreq = 1'h1;
    allow = 1'h0;
    frame = 1'h1;
    for (n = 0; n < 4; n++) begin
      tick(1);
      chk({31'h0, stop}, 32'h0);
    end
    for (n = 0; n < 6 && stop !== 1'h1; n++) tick(1);
    chk({31'h0, stop}, 32'h1);
    frame = 1'h0;
    tick(1);
    chk({31'h0, stop}, 32'h0);
    frame = 1'h1;
    tick(2);
    frame = 1'h0;
    for (n = 0; n < 10; n++) begin
      tick(1);
      chk({31'h0, stop}, 32'h0);
    end
    allow = 1'h1;
    tick(4);
    frame = 1'h1;
    for (n = 0; n < 12; n++) begin
      tick(1);
      chk({31'h0, stop}, 32'h0);
    end
    allow = 1'h0;
    for (n = 0; n < 6 && stop !== 1'h1; n++) tick(1);
    chk({31'h0, stop}, 32'h1);
    frame = 1'h0;
    mreq = 1'h0;
    tick(1);
  endtask

  task automatic t_resets;
    srst = 1'h1;
    tick(3);
    srst = 1'h0;
    rdchk(pci_cfg_pkg::OFS_LAT_CACHE, 32'h0000_04ff);
    rst = 1'h1;
    tick(4);
    rst = 1'h0;
    rdchk(pci_cfg_pkg::OFS_CMD_STATUS, 32'h0200_0000);
    rdchk(pci_cfg_pkg::OFS_LAT_CACHE, 32'h0);
    chk({24'h0, cline}, 32'h0);
  endtask

  // ------------------------------------------------------------------
  // clock, verdict, watchdog and main sequence
  // ------------------------------------------------------------------
  task automatic print_verdict;
    $display("miscompares %0d samples_checked %0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst = 1'h1;
    srst = 1'h0;
    req = '0;
    ev = '0;
    mhit = 1'h0;
    mreq = 1'h0;
    frame = 1'h0;
    allow = 1'h0;
    tick(4);
    rst = 1'h0;
    t_defaults();
    t_write_masks();
    t_gating();
    t_parity();
    t_status_events();
    t_latency();
    t_resets();
    print_verdict();
  end
endmodule
`default_nettype wire
